// File: logic/sacc_core.sv
// Serial accumulator add/subtract datapath with APB slave and interrupt.
// Assumes an APB master on clk_in and software-loaded memory operand.
`timescale 1ns/10ps
// Contract
// - Code 29 adds memory into lower
// - Add result out of range sets branch
// - Upper recirculates during add-to-lower
// - Accumulator is input one, memory two
// - Carry cleared at each sign time
// - Sign-time overflow test sets branch
// - Code 30 subtracts memory from upper
// - Code 31 subtracts memory from lower
// - Subtract select held through subtraction
// - Subtract result out of range sets branch
// - Lower recirculates during subtract-from-upper
// - Upper recirculates during subtract-from-lower
// - Difference bits written as formed
// - Borrow forced off at sign time
// - Code 28 keeps subtract select off
module sacc_core
	import sacc_pkg::*;
#(
	parameter int WORD_W = SACC_WORD_W
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Status
	output logic branch_out,
	output logic busy_out,
	output logic irq_out
);
	// Bit counter sized to the word; last data bit ends the run
	localparam int CNT_W = $clog2(WORD_W);
	localparam logic [CNT_W-1:0] LAST_DATA_BIT = CNT_W'(WORD_W - 2);
	sacc_state_t state;
	logic [WORD_W-1:0] upper;
	logic [WORD_W-1:0] lower;
	logic [WORD_W-1:0] mem_word;
	logic [SACC_CMD_W-1:0] cmd;
	logic [CNT_W-1:0] bit_cnt;
	logic branch;
	logic [SACC_IRQ_W-1:0] irq_stat;
	logic [SACC_IRQ_W-1:0] irq_mask;
	logic [31:0] prdata;
	logic wr_acc;
	logic rd_acc;
	logic start;
	logic subtract;
	logic to_upper;
	logic running;
	logic sign_time;
	logic op1;
	logic sum_bit;
	logic overflow;
	logic ovf_evt;
	logic done_evt;
	logic wr_ctrl;
	logic wr_upper;
	logic wr_lower;
	logic wr_mem;
	logic wr_mask;
	logic rd_irq;
	logic [SACC_IRQ_W-1:0] irq_read;

	// ************************************************
	// Command decode
	// ************************************************
	function automatic logic cmd_valid(input logic [SACC_CMD_W-1:0] c);
		cmd_valid = (c == SACC_CMD_ADU) || (c == SACC_CMD_ADL) ||
			(c == SACC_CMD_SBU) || (c == SACC_CMD_SBL);
	endfunction

	// Code 28 and 29 add, 30 and 31 subtract
	assign subtract = (cmd == SACC_CMD_SBU) || (cmd == SACC_CMD_SBL);
	assign to_upper = (cmd == SACC_CMD_ADU) || (cmd == SACC_CMD_SBU);
	assign running = (state == SACC_OP_RUN) || (state == SACC_OP_SIGN);
	assign sign_time = (state == SACC_OP_SIGN);
	// Target accumulator bit first, memory bit second
	assign op1 = to_upper ? upper[0] : lower[0];

	sacc_serial_alu u_alu (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.bit_en_in(running),
		.sign_time_in(sign_time),
		.subtract_in(subtract),
		.op1_in(op1),
		.op2_in(mem_word[0]),
		.sum_out(sum_bit),
		.overflow_out(overflow)
	);

	// ************************************************
	// APB access
	// ************************************************
	assign wr_acc = psel_in && penable_in && pwrite_in;
	assign rd_acc = psel_in && penable_in && !pwrite_in;
	// START only from idle, so a write in the DONE cycle cannot
	// change the command while nothing runs
	assign start = wr_ctrl && pwdata_in[SACC_CTRL_START] &&
		(state == SACC_OP_IDLE) &&
		cmd_valid(pwdata_in[SACC_CMD_W-1:0]);
	assign pready_out = 1'b1;
	assign ovf_evt = running && overflow;
	assign done_evt = sign_time;

	// ************************************************
	// Register strobes
	// ************************************************
	// Decoded once, shared by every register process
	assign wr_ctrl = wr_acc && (paddr_in == SACC_REG_CTRL);
	assign wr_upper = wr_acc && (paddr_in == SACC_REG_UPPER);
	assign wr_lower = wr_acc && (paddr_in == SACC_REG_LOWER);
	assign wr_mem = wr_acc && (paddr_in == SACC_REG_MEM);
	assign wr_mask = wr_acc && (paddr_in == SACC_REG_IRQ_MASK);
	assign rd_irq = rd_acc && (paddr_in == SACC_REG_IRQ_STAT);

	always_comb begin
		prdata = SACC_SLVERR_DATA;
		if (paddr_in == SACC_REG_CTRL) begin
			prdata = {{(32-SACC_CMD_W){1'b0}}, cmd};
		end else if (paddr_in == SACC_REG_STAT) begin
			prdata[SACC_STAT_BUSY] = running;
			prdata[SACC_STAT_BRANCH] = branch;
			prdata[SACC_STAT_SUB] = subtract;
		end else if (paddr_in == SACC_REG_UPPER) begin
			prdata = upper;
		end else if (paddr_in == SACC_REG_LOWER) begin
			prdata = lower;
		end else if (paddr_in == SACC_REG_MEM) begin
			prdata = mem_word;
		end else if (paddr_in == SACC_REG_IRQ_STAT) begin
			prdata[SACC_IRQ_W-1:0] = irq_stat;
		end else if (paddr_in == SACC_REG_IRQ_MASK) begin
			prdata[SACC_IRQ_W-1:0] = irq_mask;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			prdata_out <= SACC_RESET_WORD;
		end else if (psel_in && !penable_in) begin
			prdata_out <= prdata;
		end
	end

	// Status bits shown to a read; only these are cleared, so an
	// event landing between setup and access is not lost
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			irq_read <= '0;
		end else if (psel_in && !penable_in) begin
			irq_read <= irq_stat;
		end
	end

	// Unmapped addresses answer with an error
	always_comb begin
		pslverr_out = 1'b0;
		if (psel_in && penable_in && (paddr_in > SACC_REG_IRQ_MASK ||
			paddr_in[1:0] != 2'b00)) begin
			pslverr_out = 1'b1;
		end
	end

	// ************************************************
	// Sequencer
	// ************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state <= SACC_OP_IDLE;
			bit_cnt <= '0;
		end else begin
			case (state)
				SACC_OP_IDLE: begin
					bit_cnt <= '0;
					if (start) begin
						state <= SACC_OP_RUN;
					end
				end
				SACC_OP_RUN: begin
					bit_cnt <= bit_cnt + 1'b1;
					if (bit_cnt == LAST_DATA_BIT) begin
						state <= SACC_OP_SIGN;
					end
				end
				SACC_OP_SIGN: begin
					state <= SACC_OP_DONE;
				end
				// One dead cycle after each word before a new START
				SACC_OP_DONE: begin
					state <= SACC_OP_IDLE;
				end
				default: begin
					state <= SACC_OP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cmd <= SACC_CMD_ADU;
		end else if (start) begin
			cmd <= pwdata_in[SACC_CMD_W-1:0];
		end
	end

	// ************************************************
	// Accumulators
	// ************************************************
	// Software writes are ignored while a word period runs
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			upper <= SACC_RESET_WORD;
		end else if (running) begin
			if (to_upper) begin
				upper <= {sum_bit, upper[WORD_W-1:1]};
			end else begin
				upper <= {upper[0], upper[WORD_W-1:1]};
			end
		end else if (wr_upper) begin
			upper <= pwdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			lower <= SACC_RESET_WORD;
		end else if (running) begin
			if (!to_upper) begin
				lower <= {sum_bit, lower[WORD_W-1:1]};
			end else begin
				lower <= {lower[0], lower[WORD_W-1:1]};
			end
		end else if (wr_lower) begin
			lower <= pwdata_in;
		end
	end

	// Memory operand circulates like the drum track
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mem_word <= SACC_RESET_WORD;
		end else if (running) begin
			mem_word <= {mem_word[0], mem_word[WORD_W-1:1]};
		end else if (wr_mem) begin
			mem_word <= pwdata_in;
		end
	end

	// ************************************************
	// Branch control and interrupts
	// ************************************************
	// Overflow set wins over a software clear
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			branch <= 1'b0;
		end else if (ovf_evt) begin
			branch <= 1'b1;
		end else if (wr_ctrl && pwdata_in[SACC_CTRL_CLR_BR]) begin
			branch <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			irq_stat <= '0;
		end else begin
			for (int i = 0; i < SACC_IRQ_W; i++) begin
				if ((i == SACC_IRQ_DONE && done_evt) ||
					(i == SACC_IRQ_OVF && ovf_evt)) begin
					irq_stat[i] <= 1'b1;
				end else if (rd_irq && irq_read[i]) begin
					irq_stat[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			irq_mask <= '0;
		end else if (wr_mask) begin
			irq_mask <= pwdata_in[SACC_IRQ_W-1:0];
		end
	end

	assign irq_out = |(irq_stat & irq_mask);
	assign branch_out = branch;
	assign busy_out = running;
endmodule

// File: logic/sacc_pkg.sv
// Constants and command codes for the serial accumulator add/subtract block.
// Assumes a 40 MHz system clock and an APB register interface.
package sacc_pkg;
	localparam int SACC_WORD_W = 32;
	localparam int SACC_CMD_W = 5;
	localparam logic [4:0] SACC_CMD_ADU = 5'h1c;
	localparam logic [4:0] SACC_CMD_ADL = 5'h1d;
	localparam logic [4:0] SACC_CMD_SBU = 5'h1e;
	localparam logic [4:0] SACC_CMD_SBL = 5'h1f;
	// APB register byte offsets
	localparam logic [7:0] SACC_REG_CTRL = 8'h00;
	localparam logic [7:0] SACC_REG_STAT = 8'h04;
	localparam logic [7:0] SACC_REG_UPPER = 8'h08;
	localparam logic [7:0] SACC_REG_LOWER = 8'h0c;
	localparam logic [7:0] SACC_REG_MEM = 8'h10;
	localparam logic [7:0] SACC_REG_IRQ_STAT = 8'h14;
	localparam logic [7:0] SACC_REG_IRQ_MASK = 8'h18;
	// CTRL fields
	localparam int SACC_CTRL_START = 8;
	localparam int SACC_CTRL_CLR_BR = 9;
	// STAT fields
	localparam int SACC_STAT_BUSY = 0;
	localparam int SACC_STAT_BRANCH = 1;
	localparam int SACC_STAT_SUB = 2;
	// Interrupt bits
	localparam int SACC_IRQ_DONE = 0;
	localparam int SACC_IRQ_OVF = 1;
	localparam int SACC_IRQ_W = 2;
	localparam logic [31:0] SACC_RESET_WORD = 32'h0000_0000;
	localparam logic [31:0] SACC_SLVERR_DATA = 32'h0000_0000;
	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		SACC_OP_IDLE = 4'b0001,
		SACC_OP_RUN = 4'b0010,
		SACC_OP_SIGN = 4'b0100,
		SACC_OP_DONE = 4'b1000
	} sacc_state_t;
endpackage

// File: logic/sacc_serial_alu.sv
// One-bit serial adder/subtractor with carry/borrow and overflow test.
// Assumes bits arrive least significant first, the sign bit last.
`timescale 1ns/10ps
module sacc_serial_alu
	import sacc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// Bit stream
	input wire logic bit_en_in,
	input wire logic sign_time_in,
	input wire logic subtract_in,
	input wire logic op1_in,
	input wire logic op2_in,
	// Results
	output logic sum_out,
	output logic overflow_out
);
	logic carry;

	// ************************************************
	// Sum bit
	// ************************************************
	assign sum_out = carry ^ op1_in ^ op2_in;

	// Overflow seen only at sign time
	always_comb begin
		if (subtract_in) begin
			overflow_out = sign_time_in & ((!carry & !op1_in & op2_in) |
				(carry & op1_in & !op2_in));
		end else begin
			overflow_out = sign_time_in & ((!carry & op1_in & op2_in) |
				(carry & !op1_in & !op2_in));
		end
	end

	// ************************************************
	// Carry / borrow
	// ************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			carry <= 1'b0;
		end else if (bit_en_in) begin
			if (sign_time_in) begin
				carry <= 1'b0;
			end else if (subtract_in) begin
				carry <= (!op1_in & op2_in) | (carry & !(op1_in ^ op2_in));
			end else begin
				carry <= (op1_in & op2_in) | (carry & (op1_in ^ op2_in));
			end
		end
	end
endmodule

// File: verif/sacc_apb_host.sv
// APB host model standing in for software on the register side.
// Assumes a slave on the same clock; waits for pready however long.
`timescale 1ns/10ps
module sacc_apb_host (
	// Clock and answer
	input wire logic clk_in,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in,
	// Request
	output logic psel_out = 1'b0,
	output logic penable_out = 1'b0,
	output logic pwrite_out = 1'b0,
	output logic [7:0] paddr_out = 8'h00,
	output logic [31:0] pwdata_out = 32'h0000_0000
);
	// Request held until the edge that samples pready
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		penable_out <= 1'b1;
		do @(posedge clk_in); while (pready_in !== 1'b1);
		q = prdata_in;
		e = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
	endtask
endmodule

// File: verif/sacc_core_checker.sv
// Port assertions for the serial accumulator core.
// Assumes it is bound to sacc_core and sees only its ports.
`timescale 1ns/10ps
module sacc_core_checker
	import sacc_pkg::*;
(
	// Watched ports
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pslverr_out,
	input wire logic branch_out,
	input wire logic busy_out,
	input wire logic irq_out
);
	logic acc, wr_ctrl, start_ok, busy_q, sub_q;
	logic [5:0] cnt;
	assign acc = psel_in && penable_in;
	assign wr_ctrl = acc && pwrite_in && paddr_in == SACC_REG_CTRL;
	// Start in the done cycle is ignored, hence busy_q
	assign start_ok = wr_ctrl && pwdata_in[8] && &pwdata_in[4:2]
		&& !busy_out && !busy_q;
	always_ff @(posedge clk_in) begin
		busy_q <= srst_in ? 1'b0 : busy_out;
		cnt <= (srst_in || !busy_out) ? 6'h00 : cnt + 6'h01;
		if (start_ok) begin
			sub_q <= &pwdata_in[4:1];
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	start_busy_a: assert property (start_ok |=> busy_out)
		else $error("accepted start did not raise busy");
	bad_code_a: assert property (wr_ctrl && pwdata_in[8]
		&& !(&pwdata_in[4:2]) && !busy_out |=> !busy_out)
		else $error("start with a foreign code ran");
	word_len_a: assert property ($fell(busy_out) |-> cnt == 6'h20)
		else $error("word period is not 32 cycles");
	branch_time_a: assert property ($rose(branch_out)
		|-> $fell(busy_out))
		else $error("branch set outside sign time");
	branch_hold_a: assert property (!branch_out && $past(branch_out)
		&& !$past(srst_in) |-> $past(wr_ctrl && pwdata_in[9]))
		else $error("branch dropped without a clear");
	sub_flag_a: assert property (acc && !pwrite_in
		&& paddr_in == SACC_REG_STAT && busy_out && busy_q
		|-> prdata_out[2] == sub_q)
		else $error("subtract select wrong during run");
	irq_time_a: assert property ($rose(irq_out) |-> $fell(busy_out)
		|| $past(acc && pwrite_in && paddr_in == SACC_REG_IRQ_MASK))
		else $error("interrupt rose outside command end");
	unmapped_err_a: assert property (acc && paddr_in > SACC_REG_IRQ_MASK
		|-> pslverr_out)
		else $error("unmapped access not refused");
	cover property (start_ok);
	cover property ($rose(branch_out));
	cover property ($rose(irq_out));
endmodule
bind sacc_core sacc_core_checker chk (.clk_in(clk_in), .srst_in(srst_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
	.pslverr_out(pslverr_out), .branch_out(branch_out),
	.busy_out(busy_out), .irq_out(irq_out));

// File: verif/tb.sv
// Testbench: runs each command code through the register bus.
// Assumes sacc_core with the host model and the bound checker.
`timescale 1ns/10ps
module tb
	import sacc_pkg::*;
;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, branch, busy, irq, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	logic [4:0] cv [6] = '{5'h1c, 5'h1d, 5'h1d, 5'h1e, 5'h1f, 5'h1f};
	logic [31:0] av [6] = '{32'h4000_0000, 32'h0000_0001, 32'h8000_0000,
		32'h8000_0000, 32'h0000_0005, 32'h7fff_ffff};
	logic [31:0] mv [6] = '{32'h4000_0000, 32'hffff_ffff, 32'h8000_0000,
		32'h0000_0001, 32'h0000_0007, 32'hffff_ffff};
	initial forever #12.5 clk_in = ~clk_in;
	sacc_apb_host host (.clk_in(clk_in), .prdata_in(prdata),
		.pready_in(pready), .pslverr_in(pslverr), .psel_out(psel),
		.penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
		.pwdata_out(pwdata));
	sacc_core dut (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .branch_out(branch), .busy_out(busy),
		.irq_out(irq));
	task automatic chk(input string nm, input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic summarize;
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Whole run needs about 420 cycles
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	// ****************************************
	// Command sequence
	// ****************************************
	initial begin
		logic [31:0] a, m, r, u, l;
		logic ov, sb, up, en;
		repeat (16) @(posedge clk_in);
		srst_in <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			a = av[i];
			m = mv[i];
			sb = cv[i][1];
			up = !cv[i][0];
			en = i != 1;
			r = sb ? a - m : a + m;
			ov = ((a[31] ^ m[31]) == sb) && (r[31] != a[31]);
			u = up ? a : 32'h5a5a_0f0f;
			l = up ? 32'h0f0f_a5a5 : a;
			host.xfer(1'b1, SACC_REG_UPPER, u, q, e);
			host.xfer(1'b1, SACC_REG_LOWER, l, q, e);
			host.xfer(1'b1, SACC_REG_MEM, m, q, e);
			host.xfer(1'b1, SACC_REG_IRQ_MASK, {30'h0, en, en}, q, e);
			host.xfer(1'b1, SACC_REG_CTRL, {23'h0, 4'h8, cv[i]}, q, e);
			host.xfer(1'b0, SACC_REG_STAT, 32'h0, q, e);
			chk("sub_sel", q[2], sb);
			@(posedge clk_in);
			while (busy !== 1'b0) @(posedge clk_in);
			chk("irq", irq, en);
			chk("branch", branch, ov);
			host.xfer(1'b0, SACC_REG_UPPER, 32'h0, q, e);
			chk("upper", q, up ? r : u);
			host.xfer(1'b0, SACC_REG_LOWER, 32'h0, q, e);
			chk("lower", q, up ? l : r);
			host.xfer(1'b0, SACC_REG_MEM, 32'h0, q, e);
			chk("mem", q, m);
			host.xfer(1'b0, SACC_REG_IRQ_STAT, 32'h0, q, e);
			chk("irq_stat", q, {30'h0, ov, 1'b1});
			host.xfer(1'b1, SACC_REG_CTRL, 32'h0000_0200, q, e);
			chk("irq_clr", irq, 1'b0);
		end
		@(posedge clk_in);
		chk("branch_clr", branch, 1'b0);
		host.xfer(1'b1, SACC_REG_CTRL, 32'h0000_0105, q, e);
		repeat (2) @(posedge clk_in);
		chk("bad_code", busy, 1'b0);
		host.xfer(1'b0, 8'h1c, 32'h0, q, e);
		chk("unmapped_err", e, 1'b1);
		chk("unmapped_data", q, 32'h0000_0000);
		summarize();
	end
endmodule
